// ### hdl/cr_agu.sv
// Purpose: effective address generation for all addressing forms
// Assumes: 16-bit linear address space, registers are never addresses
// Notes: post-increment is reported, the caller updates the pointer
`timescale 1ns/1ps
module cr_agu (
  // addressing request
  input cr_pkg::cr_mode_e mode,
  input wire logic [15:0] imm,
  // pointers
  input wire logic [15:0] hx,
  input wire logic [15:0] stk,
  input wire logic [15:0] fp,
  // result
  output logic [15:0] ea,
  output logic post_inc
);
  import cr_pkg::*;
  logic [15:0] off8;
  logic [15:0] soff8;

  assign off8 = {8'h00, imm[7:0]};
  assign soff8 = {{8{imm[7]}}, imm[7:0]};

  always_comb begin
    post_inc = 1'b0;
    ea = fp;
    case (mode)
      AM_DIR: ea = {DIRECT_PAGE, imm[7:0]};
      AM_EXT: ea = imm;
      AM_IX: ea = hx;
      AM_IX1: ea = hx + off8;
      AM_IX2: ea = hx + imm;
      AM_IXP: begin
        ea = hx;
        post_inc = 1'b1;
      end
      AM_IX1P: begin
        ea = hx + off8;
        post_inc = 1'b1;
      end
      AM_TOP1: ea = stk + off8;
      AM_TOP2: ea = stk + imm;
      AM_REL: ea = fp + soff8;
      default: ea = fp;
    endcase
  end
endmodule

// ### hdl/cr_alu.sv
// Purpose: 8-bit ALU with multiply and divide
// Assumes: purely combinational, operand a is the accumulator or low index
// Notes: divide reports an error and still drives the truncated quotient on quot
`timescale 1ns/1ps
module cr_alu #(
  parameter int W = 8
) (
  // operation
  input cr_pkg::cr_alu_e op,
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic ci,
  output logic [W-1:0] res,
  output logic co,
  // multiply and divide
  input wire logic [W-1:0] div_hi,
  output logic [2*W-1:0] prod,
  output logic [W-1:0] quot,
  output logic [W-1:0] rem,
  output logic div_err
);
  import cr_pkg::*;
  logic [2*W-1:0] dividend;
  logic [2*W-1:0] divisor;

  if (W < 2) begin : g_bad_width
    $error("cr_alu: W must be at least 2");
  end

  always_comb begin
    co = ci;
    res = a;
    unique case (op)
      AL_ADD: {co, res} = {1'b0, a} + {1'b0, b};
      AL_ADC: {co, res} = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, ci};
      AL_SUB: {co, res} = {1'b0, a} - {1'b0, b};
      AL_AND: res = a & b;
      AL_OR: res = a | b;
      AL_XOR: res = a ^ b;
      AL_LD: res = b;
      AL_CLR: res = '0;
      AL_INC: res = a + {{(W-1){1'b0}}, 1'b1};
      AL_DEC: res = a - {{(W-1){1'b0}}, 1'b1};
      AL_COM: {co, res} = {1'b1, ~a};
      AL_NEG: {co, res} = {(W+1){1'b0}} - {1'b0, a};
      AL_LSL: {co, res} = {a, 1'b0};
      AL_LSR: {res, co} = {1'b0, a};
      AL_ROL: {co, res} = {a, ci};
      AL_ROR: {res, co} = {ci, a};
    endcase
  end

  // a zero divisor is replaced so the divider never sees it
  assign dividend = {div_hi, a};
  assign divisor = (b == '0) ? {{(2*W-1){1'b0}}, 1'b1} : {{W{1'b0}}, b};
  assign div_err = (b == '0) || (div_hi >= b);
  assign prod = {{W{1'b0}}, a} * {{W{1'b0}}, b};
  always_comb begin
    logic [2*W-1:0] q;
    logic [2*W-1:0] r;
    q = dividend / divisor;
    r = dividend % divisor;
    quot = q[W-1:0];
    rem = r[W-1:0];
  end
endmodule

// ### hdl/cr_core.sv
// Purpose: programmer-visible register set and datapath sequencing
// Assumes: memory answers a read one cycle after mem_rd is seen
// Notes: registers are visible only on ports, never on the address bus
`timescale 1ns/1ps
module cr_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // decoded command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input cr_pkg::cr_op_e cmd_op,
  input cr_pkg::cr_mode_e cmd_mode,
  input cr_pkg::cr_alu_e cmd_alu,
  input cr_pkg::cr_move_e cmd_move,
  input wire logic [15:0] cmd_imm,
  input wire logic cmd_cond,
  // returned bytes
  output logic [7:0] fetch_data,
  output logic fetch_valid,
  // memory bus
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // power
  input wire logic wake,
  output logic stop_mode,
  output logic wait_mode,
  // register view
  output logic [7:0] acc,
  output logic [15:0] idx_ptr,
  output logic [15:0] stack_top_pointer,
  output logic [15:0] fetch_pointer,
  output logic alu_carry,
  output logic div_err,
  output logic running
);
  import cr_pkg::*;

  cr_state_e state_reg;
  cr_op_e op_reg;
  cr_alu_e alu_op_reg;
  logic [7:0] acc_reg;
  logic [7:0] idx_hi_reg;
  logic [7:0] idx_lo_reg;
  logic [15:0] stk_reg;
  logic [15:0] fp_reg;
  logic [7:0] vec_hi_reg;
  logic [15:0] dst_reg;
  logic carry_reg;
  logic div_err_reg;
  logic stop_reg;
  logic wait_reg;
  logic [7:0] fetch_data_reg;
  logic fetch_valid_reg;
  logic [15:0] mem_addr_reg;
  logic mem_rd_reg;
  logic mem_wr_reg;
  logic [7:0] mem_wdata_reg;
  logic wake_meta_reg;
  logic wake_sync_reg;

  logic take;
  logic [15:0] hx;
  logic [15:0] ea;
  logic agu_post;
  logic hx_inc;
  logic [15:0] mv_src;
  logic [15:0] mv_dst;
  logic mv_inc;
  logic iss_rd;
  logic iss_wr;
  logic [15:0] iss_addr;
  logic [7:0] iss_data;
  cr_alu_e alu_op;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_co;
  logic [15:0] prod;
  logic [7:0] quot;
  logic [7:0] rem;
  logic dv_err;
  logic alu_now;
  logic alu_late;

  assign hx = {idx_hi_reg, idx_lo_reg};
  assign cmd_ready = (state_reg == ST_IDLE);
  assign take = cmd_valid && cmd_ready;

  cr_agu u_agu (
    .mode(cmd_mode),
    .imm(cmd_imm),
    .hx(hx),
    .stk(stk_reg),
    .fp(fp_reg),
    .ea(ea),
    .post_inc(agu_post)
  );

  // alu sees the pending operation while the memory operand returns
  assign alu_late = (state_reg == ST_RD2) && (op_reg == OP_ALU_A);
  assign alu_now = take && ((cmd_op == OP_ALU_X) ||
                            (cmd_op == OP_ALU_A && cmd_mode == AM_IMM));
  assign alu_op = alu_late ? alu_op_reg : cmd_alu;
  assign alu_a = (!alu_late && cmd_op == OP_ALU_X) ? idx_lo_reg : acc_reg;
  assign alu_b = alu_late ? mem_rdata :
                 (cmd_op == OP_MUL || cmd_op == OP_DIV) ? idx_lo_reg : cmd_imm[7:0];

  cr_alu #(.W(8)) u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .ci(carry_reg),
    .res(alu_res),
    .co(alu_co),
    .div_hi(idx_hi_reg),
    .prod(prod),
    .quot(quot),
    .rem(rem),
    .div_err(dv_err)
  );

  // four move forms, direct bytes come from the instruction stream
  always_comb begin
    mv_src = {DIRECT_PAGE, cmd_imm[7:0]};
    mv_dst = {DIRECT_PAGE, cmd_imm[15:8]};
    mv_inc = 1'b0;
    unique case (cmd_move)
      MV_DD: mv_dst = {DIRECT_PAGE, cmd_imm[15:8]};
      MV_DIXP: begin
        mv_dst = hx;
        mv_inc = 1'b1;
      end
      MV_IXPD: begin
        mv_src = hx;
        mv_inc = 1'b1;
      end
      MV_IMD: mv_src = fp_reg;
    endcase
  end

  assign hx_inc = take && ((agu_post && (cmd_op == OP_ALU_A || cmd_op == OP_STA ||
                                         cmd_op == OP_JUMP)) ||
                           (cmd_op == OP_MOVE && mv_inc));

  // memory request for the next cycle; core registers never go on the bus
  always_comb begin
    iss_rd = 1'b0;
    iss_wr = 1'b0;
    iss_addr = fp_reg;
    iss_data = acc_reg;
    unique case (state_reg)
      ST_V0: begin
        iss_rd = 1'b1;
        iss_addr = VEC_HI_ADDR;
      end
      ST_V1: begin
        iss_rd = 1'b1;
        iss_addr = VEC_LO_ADDR;
      end
      ST_IDLE: begin
        if (cmd_valid) begin
          case (cmd_op)
            OP_FETCH: iss_rd = 1'b1;
            OP_ALU_A: begin
              iss_rd = (cmd_mode != AM_IMM);
              iss_addr = ea;
            end
            OP_STA: begin
              iss_wr = 1'b1;
              iss_addr = ea;
            end
            OP_PUSH: begin
              iss_wr = 1'b1;
              iss_addr = stk_reg;
              iss_data = cmd_imm[7:0];
            end
            OP_PULL: begin
              iss_rd = 1'b1;
              iss_addr = stk_reg + ONE16;
            end
            OP_MOVE: begin
              iss_rd = (cmd_move != MV_IMD);
              iss_wr = (cmd_move == MV_IMD);
              iss_addr = (cmd_move == MV_IMD) ? mv_dst : mv_src;
              iss_data = cmd_imm[7:0];
            end
            default: iss_rd = 1'b0;
          endcase
        end
      end
      ST_RD2: begin
        iss_wr = (op_reg == OP_MOVE);
        iss_addr = dst_reg;
        iss_data = mem_rdata;
      end
      ST_V2, ST_V3, ST_RD1, ST_LOWP: iss_rd = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_addr_reg <= FP_RST;
      mem_wdata_reg <= 8'h00;
    end else begin
      mem_rd_reg <= iss_rd;
      mem_wr_reg <= iss_wr;
      mem_addr_reg <= iss_addr;
      mem_wdata_reg <= iss_data;
    end
  end

  // wake may come from a pin, so it is synchronised first
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= wake;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_V0;
    end else begin
      unique case (state_reg)
        ST_V0: state_reg <= ST_V1;
        ST_V1: state_reg <= ST_V2;
        ST_V2: state_reg <= ST_V3;
        ST_V3: state_reg <= ST_IDLE;
        ST_IDLE: begin
          if (cmd_valid) begin
            if (iss_rd) begin
              state_reg <= ST_RD1;
            end else if (cmd_op == OP_STOP || cmd_op == OP_WAIT) begin
              state_reg <= ST_LOWP;
            end
          end
        end
        ST_RD1: state_reg <= ST_RD2;
        ST_RD2: state_reg <= ST_IDLE;
        ST_LOWP: begin
          if (wake_sync_reg) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      op_reg <= OP_NOP;
      alu_op_reg <= AL_ADD;
      dst_reg <= FP_RST;
    end else if (take) begin
      op_reg <= cmd_op;
      alu_op_reg <= cmd_alu;
      dst_reg <= mv_dst;
    end
  end

  // accumulator and low index byte have no reset term at all
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      idx_hi_reg <= IDX_HI_RST;
    end else begin
      if (alu_late) begin
        acc_reg <= alu_res;
      end else if (alu_now && cmd_op == OP_ALU_A) begin
        acc_reg <= alu_res;
      end else if (alu_now) begin
        idx_lo_reg <= alu_res;
      end else if (take && cmd_op == OP_XCHG) begin
        acc_reg <= idx_lo_reg;
        idx_lo_reg <= acc_reg;
      end else if (take && cmd_op == OP_LDHX) begin
        idx_hi_reg <= cmd_imm[15:8];
        idx_lo_reg <= cmd_imm[7:0];
      end else if (take && cmd_op == OP_MUL) begin
        idx_lo_reg <= prod[15:8];
        acc_reg <= prod[7:0];
      end else if (take && cmd_op == OP_DIV && !dv_err) begin
        acc_reg <= quot;
        idx_hi_reg <= rem;
      end else if (hx_inc) begin
        {idx_hi_reg, idx_lo_reg} <= hx + ONE16;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      carry_reg <= 1'b0;
      div_err_reg <= 1'b0;
    end else begin
      if (alu_late || alu_now) begin
        carry_reg <= alu_co;
      end
      div_err_reg <= take && (cmd_op == OP_DIV) && dv_err;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stk_reg <= TOP_RST;
    end else if (take) begin
      case (cmd_op)
        OP_ADJ: stk_reg <= stk_reg + {{8{cmd_imm[7]}}, cmd_imm[7:0]};
        OP_SLR: stk_reg <= {stk_reg[15:8], TOP_LOW_RST};
        OP_PUSH: stk_reg <= stk_reg - ONE16;
        OP_PULL: stk_reg <= stk_reg + ONE16;
        default: stk_reg <= stk_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fp_reg <= FP_RST;
      vec_hi_reg <= 8'h00;
    end else if (state_reg == ST_V2) begin
      vec_hi_reg <= mem_rdata;
    end else if (state_reg == ST_V3) begin
      fp_reg <= {vec_hi_reg, mem_rdata};
    end else if (take) begin
      case (cmd_op)
        OP_FETCH: fp_reg <= fp_reg + ONE16;
        OP_JUMP: fp_reg <= ea;
        OP_BRANCH: begin
          if (cmd_cond) begin
            fp_reg <= fp_reg + {{8{cmd_imm[7]}}, cmd_imm[7:0]};
          end
        end
        default: fp_reg <= fp_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fetch_data_reg <= 8'h00;
      fetch_valid_reg <= 1'b0;
    end else begin
      fetch_valid_reg <= (state_reg == ST_RD2) &&
                         (op_reg == OP_FETCH || op_reg == OP_PULL);
      if (state_reg == ST_RD2) begin
        fetch_data_reg <= mem_rdata;
      end
    end
  end

  // the low-power flags hold until a synchronised wake arrives
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stop_reg <= 1'b0;
      wait_reg <= 1'b0;
    end else if (take && cmd_op == OP_STOP) begin
      stop_reg <= 1'b1;
    end else if (take && cmd_op == OP_WAIT) begin
      wait_reg <= 1'b1;
    end else if (state_reg == ST_LOWP && wake_sync_reg) begin
      stop_reg <= 1'b0;
      wait_reg <= 1'b0;
    end
  end

  assign mem_addr = mem_addr_reg;
  assign mem_rd = mem_rd_reg;
  assign mem_wr = mem_wr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign fetch_data = fetch_data_reg;
  assign fetch_valid = fetch_valid_reg;
  assign stop_mode = stop_reg;
  assign wait_mode = wait_reg;
  assign acc = acc_reg;
  assign idx_ptr = hx;
  assign stack_top_pointer = stk_reg;
  assign fetch_pointer = fp_reg;
  assign alu_carry = carry_reg;
  assign div_err = div_err_reg;
  assign running = (state_reg != ST_V0) && (state_reg != ST_V1) &&
                   (state_reg != ST_V2) && (state_reg != ST_V3);
endmodule

// ### hdl/cr_pkg.sv
// Purpose: constants and types shared by the processor register set
// Assumes: one core clock, synchronous active-high reset
// Notes: the register set is driven by an external decoder through a command port
// Summary of operation
// - Reset leaves the accumulator unchanged.
// - Reset clears the high index byte; the low index byte is kept.
// - Reset loads the stack top pointer with 0x00FF.
// - After reset the fetch pointer is loaded from the vector at 0xFFFE/0xFFFF.
// - Each sequential byte fetch advances the fetch pointer by one.
// - Jumps and taken branches load a new target.
// - The stack top pointer addresses the next free byte of a downward stack.
// - Stack adjust adds a sign-extended 8-bit immediate to the full pointer.
// - Stack low reset changes only the low byte of the stack top pointer.
// - Indexed forms use high:low index bytes as one 16-bit pointer.
// - The low index byte supports unary operations and exchange with accumulator.
// - The accumulator feeds one ALU input and receives ALU results.
// - Core registers are not addressable; memory is one 64-Kbyte space.
// - Direct addressing reaches only 0x0000 to 0x00FF with one address byte.
// - Relative addressing adds a signed 8-bit offset to form the target.
// - Five index-relative forms exist, some incrementing the pointer after use.
// - The datapath does 8x8 multiply and 16/8 divide.
// - Memory-to-memory moves exist in four source/destination combinations.
// - Stop and wait commands signal entry into low-power modes.
package cr_pkg;
  localparam logic [15:0] TOP_RST = 16'h00FF;
  localparam logic [7:0] TOP_LOW_RST = 8'hFF;
  localparam logic [7:0] IDX_HI_RST = 8'h00;
  localparam logic [15:0] FP_RST = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [15:0] ONE16 = 16'h0001;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_FETCH = 5'h01, OP_JUMP = 5'h02, OP_BRANCH = 5'h03,
    OP_ALU_A = 5'h04, OP_ALU_X = 5'h05, OP_STA = 5'h06, OP_LDHX = 5'h07,
    OP_XCHG = 5'h08, OP_ADJ = 5'h09, OP_SLR = 5'h0A, OP_PUSH = 5'h0B,
    OP_PULL = 5'h0C, OP_MUL = 5'h0D, OP_DIV = 5'h0E, OP_MOVE = 5'h0F,
    OP_STOP = 5'h10, OP_WAIT = 5'h11
  } cr_op_e;

  typedef enum logic [3:0] {
    AM_IMM = 4'h0, AM_DIR = 4'h1, AM_EXT = 4'h2, AM_IX = 4'h3,
    AM_IX1 = 4'h4, AM_IX2 = 4'h5, AM_IXP = 4'h6, AM_IX1P = 4'h7,
    AM_TOP1 = 4'h8, AM_TOP2 = 4'h9, AM_REL = 4'hA
  } cr_mode_e;

  typedef enum logic [3:0] {
    AL_ADD = 4'h0, AL_ADC = 4'h1, AL_SUB = 4'h2, AL_AND = 4'h3,
    AL_OR = 4'h4, AL_XOR = 4'h5, AL_LD = 4'h6, AL_CLR = 4'h7,
    AL_INC = 4'h8, AL_DEC = 4'h9, AL_COM = 4'hA, AL_NEG = 4'hB,
    AL_LSL = 4'hC, AL_LSR = 4'hD, AL_ROL = 4'hE, AL_ROR = 4'hF
  } cr_alu_e;

  typedef enum logic [1:0] {
    MV_DD = 2'h0, MV_DIXP = 2'h1, MV_IXPD = 2'h2, MV_IMD = 2'h3
  } cr_move_e;

  typedef enum logic [2:0] {
    ST_V0 = 3'h0, ST_V1 = 3'h1, ST_V2 = 3'h2, ST_V3 = 3'h3,
    ST_IDLE = 3'h4, ST_RD1 = 3'h5, ST_RD2 = 3'h6, ST_LOWP = 3'h7
  } cr_state_e;
endpackage

// ### sim/cr_core_sva.sv
// Purpose: concurrent checks on the register set ports
// Assumes: memory answers one cycle after a read strobe
// Notes: reset checks override the default disable because they watch reset itself
`timescale 1ns/1ps
module cr_core_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // command
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input cr_pkg::cr_op_e cmd_op,
  input cr_pkg::cr_mode_e cmd_mode,
  input wire logic [15:0] cmd_imm,
  input wire logic cmd_cond,
  // memory and status
  input wire logic [7:0] fetch_data,
  input wire logic fetch_valid,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic stop_mode,
  input wire logic running,
  // registers
  input wire logic [7:0] acc,
  input wire logic [15:0] idx_ptr,
  input wire logic [15:0] stack_top_pointer,
  input wire logic [15:0] fetch_pointer
);
  import cr_pkg::*;
  logic take;
  logic [15:0] sx;
  assign take = cmd_valid && cmd_ready;
  assign sx = {{8{cmd_imm[7]}}, cmd_imm[7:0]};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_RST_TOP: assert property (disable iff (1'b0) sys_rst |=> stack_top_pointer == 16'h00FF)
    else $error("stack top not reset");
  AST_RST_HI: assert property (disable iff (1'b0) sys_rst |=> idx_ptr[15:8] == 8'h00)
    else $error("index high not cleared");
  AST_RST_KEEP: assert property (disable iff (1'b0) $rose(sys_rst) && $past(running) |=>
    ($stable(acc) && $stable(idx_ptr[7:0]))[*3]) else $error("reset touched acc or index low");
  AST_VEC_RD: assert property ($fell(sys_rst) |=> mem_rd && mem_addr == 16'hFFFE ##1
    mem_rd && mem_addr == 16'hFFFF) else $error("vector read order");
  AST_VEC_LD: assert property ($fell(sys_rst) |-> ##4 running &&
    fetch_pointer == {$past(mem_rdata, 2), $past(mem_rdata)}) else $error("vector load");
  AST_FETCH: assert property (take && cmd_op == OP_FETCH |=> mem_rd &&
    mem_addr == $past(fetch_pointer) && fetch_pointer == $past(fetch_pointer) + 16'h0001)
    else $error("fetch pointer step");
  AST_FETCH_DATA: assert property (take && cmd_op == OP_FETCH |-> ##3 fetch_valid &&
    fetch_data == $past(mem_rdata)) else $error("fetch data");
  AST_JUMP: assert property (take && cmd_op == OP_JUMP && cmd_mode == AM_EXT |=>
    fetch_pointer == $past(cmd_imm)) else $error("jump target");
  AST_BRANCH: assert property (take && cmd_op == OP_BRANCH && cmd_mode == AM_REL |=>
    fetch_pointer == $past(fetch_pointer) + ($past(cmd_cond) ? $past(sx) : 16'h0000))
    else $error("branch target");
  AST_ADJ: assert property (take && cmd_op == OP_ADJ |=>
    stack_top_pointer == $past(stack_top_pointer) + $past(sx)) else $error("stack adjust");
  AST_SLR: assert property (take && cmd_op == OP_SLR |=>
    stack_top_pointer == {$past(stack_top_pointer[15:8]), 8'hFF}) else $error("stack low reset");
  AST_PUSH: assert property (take && cmd_op == OP_PUSH |=> mem_wr &&
    mem_addr == $past(stack_top_pointer) && stack_top_pointer == $past(stack_top_pointer) - 16'h0001)
    else $error("push");
  AST_STA_DIR: assert property (take && cmd_op == OP_STA && cmd_mode == AM_DIR |=> mem_wr &&
    mem_addr == {8'h00, $past(cmd_imm[7:0])} && mem_wdata == $past(acc)) else $error("direct store");
  AST_STOP: assert property (take && cmd_op == OP_STOP |=> stop_mode && !cmd_ready)
    else $error("stop entry");
  cover property (take && cmd_op == OP_FETCH);
  cover property (take && cmd_op == OP_BRANCH && cmd_cond);
  cover property (take && cmd_op == OP_STOP);
endmodule

// ### sim/cr_mem_model.sv
// Purpose: behavioural 64-Kbyte memory on the far side of the address bus
// Assumes: read data is due the cycle after a read strobe
// Notes: between reads the data lines toggle so a stale byte never passes for an answer
`timescale 1ns/1ps
module cr_mem_model #(
  parameter logic [15:0] VEC = 16'h1234
) (
  // clock
  input wire logic core_clk,
  // bus
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    end
    mem[16'hFFFE] = VEC[15:8];
    mem[16'hFFFF] = VEC[7:0];
    mem_rdata = 8'hA5;
  end
  always @(posedge core_clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// ### sim/test_cr_core.sv
// Purpose: self-checking bench for the processor register set
// Assumes: memory model answers one cycle after a read strobe
// Notes: outputs are judged 1 ns after an edge so register updates have landed
`timescale 1ns/1ps
module test_cr_core;
  import cr_pkg::*;
  localparam logic [15:0] VEC = 16'h1234;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_cond = 1'b0;
  logic wake = 1'b0;
  cr_op_e cmd_op = OP_NOP;
  cr_mode_e cmd_mode = AM_IMM;
  cr_alu_e cmd_alu = AL_LD;
  cr_move_e cmd_move = MV_DD;
  logic [15:0] cmd_imm = 16'h0000;
  logic cmd_ready, fetch_valid, mem_rd, mem_wr, stop_mode, wait_mode, alu_carry, div_err, running;
  logic [7:0] fetch_data, mem_wdata, mem_rdata, acc;
  logic [15:0] mem_addr, idx_ptr, stack_top_pointer, fetch_pointer;
  int n_fail = 0;
  int check_count = 0;
  always #50 core_clk = ~core_clk;
  cr_core i_dut (.core_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_mode, .cmd_alu,
    .cmd_move, .cmd_imm, .cmd_cond, .fetch_data, .fetch_valid, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .wake, .stop_mode, .wait_mode, .acc, .idx_ptr, .stack_top_pointer,
    .fetch_pointer, .alu_carry, .div_err, .running);
  cr_mem_model #(.VEC(VEC)) i_mem (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hi(input logic got);
    chk({15'h0000, got}, 16'h0001);
  endtask
  task automatic after(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // holds the command until an edge sees it accepted, then drops valid
  task automatic issue(input cr_op_e op, input logic [15:0] imm = 16'h0000,
      input cr_mode_e md = AM_IMM, input cr_alu_e al = AL_LD, input logic cnd = 1'b1,
      input cr_move_e mv = MV_DD);
    int n;
    n = 0;
    @(posedge core_clk);
    cmd_op <= op;
    cmd_imm <= imm;
    cmd_mode <= md;
    cmd_alu <= al;
    cmd_cond <= cnd;
    cmd_move <= mv;
    cmd_valid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 40);
    cmd_valid <= 1'b0;
    hi(n < 40);
  endtask
  task automatic t_reset(input logic keep);
    logic [15:0] old;
    int n;
    old = {acc, idx_ptr[7:0]};
    n = 0;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    after(4);
    chk(stack_top_pointer, 16'h00FF);
    chk({idx_ptr[15:8], 8'h00}, 16'h0000);
    if (keep) begin
      chk({acc, idx_ptr[7:0]}, old);
    end
    @(posedge core_clk);
    sys_rst <= 1'b0;
    after(1);
    chk({15'h0000, running}, 16'h0000);
    while (cmd_ready !== 1'b1 && n < 20) begin
      after(1);
      n++;
    end
    chk(fetch_pointer, VEC);
  endtask
  task automatic t_stack();
    issue(OP_ADJ, 16'h007F);
    after(0);
    chk(stack_top_pointer, 16'h017E);
    issue(OP_SLR);
    after(0);
    chk(stack_top_pointer, 16'h01FF);
    issue(OP_ADJ, 16'h0080);
    after(0);
    chk(stack_top_pointer, 16'h017F);
    issue(OP_PUSH, 16'h00C3);
    after(0);
    hi(mem_wr);
    chk({mem_addr[11:0], mem_wdata[3:0]}, 16'h17F3);
    chk(stack_top_pointer, 16'h017E);
    issue(OP_PULL);
    after(0);
    chk(mem_addr, 16'h017F);
    after(2);
    chk({stack_top_pointer[7:0], fetch_data}, 16'h7FC3);
  endtask
  task automatic t_fetch();
    logic [15:0] fp;
    for (int i = 0; i < 2; i++) begin
      fp = fetch_pointer;
      issue(OP_FETCH);
      after(0);
      hi(mem_rd);
      chk(mem_addr, fp);
      chk(fetch_pointer, fp + 16'h0001);
      after(2);
      hi(fetch_valid);
      chk({8'h00, fetch_data}, {8'h00, pat(fp)});
    end
  endtask
  task automatic t_data();
    cr_alu_e xo [7] = '{AL_CLR, AL_INC, AL_DEC, AL_COM, AL_NEG, AL_LSL, AL_LSR};
    logic [7:0] xe [7] = '{8'h00, 8'h97, 8'h95, 8'h69, 8'h6A, 8'h2C, 8'h4B};
    issue(OP_ALU_A, 16'h1000, AM_EXT);
    after(2);
    chk({8'h00, acc}, {8'h00, pat(16'h1000)});
    issue(OP_ALU_A, 16'h00FA);
    issue(OP_ALU_A, 16'h0071, AM_IMM, AL_ADD);
    after(0);
    chk({7'h00, alu_carry, acc}, 16'h016B);
    issue(OP_LDHX, 16'h2345);
    issue(OP_STA, 16'h0000, AM_IX);
    after(0);
    chk(mem_addr, 16'h2345);
    chk({8'h00, mem_wdata}, 16'h006B);
    issue(OP_STA, 16'hAB80, AM_DIR);
    after(0);
    chk(mem_addr, 16'h0080);
    issue(OP_XCHG);
    after(0);
    chk({acc, idx_ptr[7:0]}, 16'h456B);
    for (int i = 0; i < 7; i++) begin
      issue(OP_ALU_X, 16'h0096);
      issue(OP_ALU_X, 16'h0000, AM_IMM, xo[i]);
      after(0);
      chk(idx_ptr, {8'h23, xe[i]});
    end
  endtask
  task automatic t_muldiv();
    issue(OP_ALU_A, 16'h000C);
    issue(OP_ALU_X, 16'h000B);
    issue(OP_MUL);
    after(0);
    chk({idx_ptr[7:0], acc}, 16'h0084);
    issue(OP_LDHX, 16'h0107);
    issue(OP_ALU_A, 16'h0000);
    issue(OP_DIV);
    after(0);
    chk({idx_ptr[15:8], acc}, 16'h0424);
    issue(OP_LDHX, 16'h0000);
    issue(OP_DIV);
    after(0);
    hi(div_err);
    chk({8'h00, acc}, 16'h0024);
  endtask
  task automatic t_move();
    logic [15:0] mv [4] = '{16'h501A, 16'h601A, 16'h503B, 16'h5040};
    logic [15:0] hx [4] = '{16'h0060, 16'h0061, 16'h0062, 16'h0062};
    issue(OP_LDHX, 16'h0060);
    for (int m = 0; m < 4; m++) begin
      issue(OP_MOVE, 16'h5040, AM_IMM, AL_LD, 1'b1, cr_move_e'(m));
      after(m == 3 ? 0 : 2);
      hi(mem_wr);
      chk(mem_addr, {8'h00, mv[m][15:8]});
      chk({8'h00, mem_wdata}, {8'h00, mv[m][7:0]});
      after(1);
      chk(idx_ptr, hx[m]);
    end
  endtask
  task automatic t_flow();
    issue(OP_JUMP, 16'h4000, AM_EXT);
    after(0);
    chk(fetch_pointer, 16'h4000);
    issue(OP_BRANCH, 16'h00F0, AM_REL);
    after(0);
    chk(fetch_pointer, 16'h3FF0);
    issue(OP_BRANCH, 16'h0010, AM_REL, AL_LD, 1'b0);
    after(0);
    chk(fetch_pointer, 16'h3FF0);
  endtask
  task automatic t_power();
    int n;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      issue(i == 0 ? OP_STOP : OP_WAIT);
      after(0);
      hi(i == 0 ? stop_mode : wait_mode);
      chk({15'h0000, cmd_ready}, 16'h0000);
      @(posedge core_clk);
      wake <= 1'b1;
      while ((stop_mode | wait_mode) !== 1'b0 && n < 8) begin
        after(1);
        n++;
      end
      hi(n < 8);
      @(posedge core_clk);
      wake <= 1'b0;
      after(4);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    t_reset(1'b0);
    t_stack();
    t_fetch();
    t_data();
    t_muldiv();
    t_move();
    t_flow();
    t_power();
    t_reset(1'b1);
    report_and_stop();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    report_and_stop();
  end
endmodule
bind cr_core cr_core_sva i_sva (.core_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_mode,
  .cmd_imm, .cmd_cond, .fetch_data, .fetch_valid, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
  .mem_rdata, .stop_mode, .running, .acc, .idx_ptr, .stack_top_pointer, .fetch_pointer);
